// file: kcr_fabric_model.sv
// fabric model: answers the own kill request with a train of responses
`timescale 1ns/1ns
module kcr_fabric_model (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic ask_i,
	input wire logic [3:0] lat_i,
	input wire logic ok_i,
	output logic rsp_valid_o,
	output logic rsp_done_o,
	output logic rsp_final_o
);
	logic [3:0] cnt;
	// launched off the falling edge so the resolver samples settled lines
	always @(negedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt <= 4'h0;
			rsp_valid_o <= 1'h0;
			rsp_done_o <= 1'h0;
			rsp_final_o <= 1'h0;
		end else if (ask_i) begin
			cnt <= lat_i;
			rsp_valid_o <= 1'h0;
			rsp_final_o <= 1'h0;
		end else begin
			cnt <= (cnt != 4'h0) ? cnt - 4'h1 : cnt;
			rsp_valid_o <= cnt != 4'h0;
			rsp_final_o <= cnt == 4'h1;
			// idle level toggles so a stale value never passes for an answer
			rsp_done_o <= (cnt == 4'h1) ? ok_i : (cnt != 4'h0) ? 1'h1 : ~rsp_done_o;
		end
	end
endmodule : kcr_fabric_model

// file: kcr_pkg.sv
// shared types and constants of the kill collision resolver
package kcr_pkg;
	localparam int KCR_ADDR_W = 32;
	localparam int KCR_GRAN_LSB = 5;
	localparam int KCR_SRC_W = 8;

	typedef enum logic [3:0] {
		KCR_RD_HOME = 4'h0,
		KCR_IRD_HOME = 4'h1,
		KCR_RD_OWNER = 4'h2,
		KCR_RTO_HOME = 4'h3,
		KCR_RTO_OWNER = 4'h4,
		KCR_DKILL_HOME = 4'h5,
		KCR_DKILL_SHR = 4'h6,
		KCR_CASTOUT = 4'h7,
		KCR_TLB_INV = 4'h8,
		KCR_TLB_SYNC = 4'h9,
		KCR_IKILL_HOME = 4'hA,
		KCR_IKILL_SHR = 4'hB,
		KCR_FLUSH = 4'hC,
		KCR_IORD_HOME = 4'hD,
		KCR_IORD_OWNER = 4'hE
	} kcr_req_e;

	typedef enum logic [1:0] {
		KCR_OWN_DKH = 2'h0,
		KCR_OWN_DKS = 2'h1,
		KCR_OWN_IKH = 2'h2,
		KCR_OWN_IKS = 2'h3
	} kcr_own_e;

	typedef enum logic [1:0] {
		KCR_C_LIVE = 2'h0,
		KCR_C_FDONE = 2'h1,
		KCR_C_FRETRY = 2'h2,
		KCR_C_NONE = 2'h3
	} kcr_cond_e;

	typedef enum logic [3:0] {
		KCR_A_NORMAL = 4'h0,
		KCR_A_WAIT = 4'h1,
		KCR_A_ERROR = 4'h2,
		KCR_A_RETRY = 4'h3,
		KCR_A_FWD_DONE = 4'h4,
		KCR_A_FWD_INTV = 4'h5,
		KCR_A_FWD_DATA = 4'h6,
		KCR_A_CANCEL_FWD = 4'h7,
		KCR_A_FWD_BCAST = 4'h8
	} kcr_act_e;

	typedef enum logic [2:0] {
		KCR_R_NONE = 3'h0,
		KCR_R_DONE = 3'h1,
		KCR_R_ERROR = 3'h2,
		KCR_R_RETRY = 3'h3,
		KCR_R_DONE_INTV = 3'h4
	} kcr_resp_e;

	typedef enum logic {
		KCR_ST_IDLE = 1'b0,
		KCR_ST_HOLD = 1'b1
	} kcr_st_e;
endpackage : kcr_pkg

// file: kcr_resolver.sv
// kill collision resolver: tracks the own invalidate and resolves colliding requests
`timescale 1ns/1ns
module kcr_resolver #(
	parameter int ADDR_W = kcr_pkg::KCR_ADDR_W,
	parameter int GRAN_LSB = kcr_pkg::KCR_GRAN_LSB,
	parameter int SRC_W = kcr_pkg::KCR_SRC_W
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic own_issue_i,
	input wire kcr_pkg::kcr_own_e own_kind_i,
	input wire logic [ADDR_W-1:0] own_addr_i,
	input wire logic own_rsp_valid_i,
	input wire logic own_rsp_done_i,
	input wire logic own_rsp_final_i,
	input wire logic own_retire_i,
	input wire logic inc_valid_i,
	input wire kcr_pkg::kcr_req_e inc_type_i,
	input wire logic [ADDR_W-1:0] inc_addr_i,
	input wire logic [SRC_W-1:0] inc_src_i,
	input wire logic inc_home_i,
	output logic inc_ready_o,
	output logic res_valid_o,
	output kcr_pkg::kcr_resp_e res_resp_o,
	output logic res_data_o,
	output logic res_data_only_o,
	output logic res_fwd_o,
	output logic res_cancel_o,
	output logic res_bcast_o,
	output logic res_normal_o,
	output logic [SRC_W-1:0] res_src_o,
	output kcr_pkg::kcr_req_e res_type_o,
	output logic own_live_o
);
	localparam int GW = ADDR_W - GRAN_LSB;

	typedef struct packed {
		kcr_pkg::kcr_st_e st;
		logic own_valid;
		logic own_live;
		kcr_pkg::kcr_own_e own_kind;
		logic [GW-1:0] own_gran;
		kcr_pkg::kcr_req_e held;
		logic [SRC_W-1:0] held_src;
		logic held_home;
		logic ready;
		logic res_valid;
		kcr_pkg::kcr_resp_e resp;
		logic data;
		logic data_only;
		logic fwd;
		logic cancel;
		logic bcast;
		logic normal;
		logic [SRC_W-1:0] src;
		kcr_pkg::kcr_req_e rtype;
	} kcr_state_s;

	function automatic logic [GW-1:0] kcr_gran(input logic [ADDR_W-1:0] a);
		kcr_gran = a[ADDR_W-1:GRAN_LSB];
	endfunction : kcr_gran

	kcr_state_s r;
	kcr_state_s next_r;
	logic fin;
	logic hit;
	logic acc;
	kcr_pkg::kcr_cond_e cond;
	kcr_pkg::kcr_req_e tbl_req;
	logic tbl_home;
	kcr_pkg::kcr_act_e tbl_act;
	kcr_pkg::kcr_act_e act;

	assign fin = own_rsp_valid_i && own_rsp_final_i;
	// match is on the granule, not the byte address
	assign hit = r.own_valid && (kcr_gran(inc_addr_i) == r.own_gran);
	assign acc = inc_valid_i && r.ready && (r.st == kcr_pkg::KCR_ST_IDLE);
	assign tbl_req = (r.st == kcr_pkg::KCR_ST_HOLD) ? r.held : inc_type_i;
	assign tbl_home = (r.st == kcr_pkg::KCR_ST_HOLD) ? r.held_home : inc_home_i;

	// a final response in the same cycle is used at once, so a waiter never misses it
	always_comb begin
		if (fin) begin
			cond = own_rsp_done_i ? kcr_pkg::KCR_C_FDONE : kcr_pkg::KCR_C_FRETRY;
		end else if (r.own_live) begin
			cond = kcr_pkg::KCR_C_LIVE;
		end else begin
			cond = kcr_pkg::KCR_C_NONE;
		end
	end

	kcr_table u_table (
		.own_kind_i(r.own_kind),
		.req_i(tbl_req),
		.home_i(tbl_home),
		.cond_i(cond),
		.act_o(tbl_act)
	);

	assign act = (r.st == kcr_pkg::KCR_ST_HOLD || hit) ? tbl_act : kcr_pkg::KCR_A_NORMAL;

	always_comb begin
		next_r = r;
		next_r.res_valid = 1'b0;
		if (fin) begin
			next_r.own_live = 1'b0;
		end
		if (own_retire_i) begin
			next_r.own_valid = 1'b0;
		end
		if (own_issue_i) begin
			next_r.own_valid = 1'b1;
			next_r.own_live = 1'b1;
			next_r.own_kind = own_kind_i;
			next_r.own_gran = kcr_gran(own_addr_i);
		end
		case (r.st)
			kcr_pkg::KCR_ST_IDLE: begin
				if (acc && act == kcr_pkg::KCR_A_WAIT) begin
					next_r.st = kcr_pkg::KCR_ST_HOLD;
					next_r.held = inc_type_i;
					next_r.held_src = inc_src_i;
					next_r.held_home = inc_home_i;
					next_r.ready = 1'b0;
				end
			end
			kcr_pkg::KCR_ST_HOLD: begin
				if (act != kcr_pkg::KCR_A_WAIT) begin
					next_r.st = kcr_pkg::KCR_ST_IDLE;
					next_r.ready = 1'b1;
				end
			end
			default: begin
				next_r.st = kcr_pkg::KCR_ST_IDLE;
				next_r.ready = 1'b1;
			end
		endcase
		if ((acc || r.st == kcr_pkg::KCR_ST_HOLD) && act != kcr_pkg::KCR_A_WAIT) begin
			next_r.res_valid = 1'b1;
			next_r.src = (r.st == kcr_pkg::KCR_ST_HOLD) ? r.held_src : inc_src_i;
			next_r.rtype = tbl_req;
			next_r.resp = kcr_pkg::KCR_R_NONE;
			next_r.data = 1'b0;
			next_r.data_only = 1'b0;
			next_r.fwd = 1'b0;
			next_r.cancel = 1'b0;
			next_r.bcast = 1'b0;
			next_r.normal = 1'b0;
			case (act)
				kcr_pkg::KCR_A_ERROR: next_r.resp = kcr_pkg::KCR_R_ERROR;
				kcr_pkg::KCR_A_RETRY: next_r.resp = kcr_pkg::KCR_R_RETRY;
				kcr_pkg::KCR_A_FWD_DONE: begin
					next_r.fwd = 1'b1;
					next_r.resp = kcr_pkg::KCR_R_DONE;
				end
				kcr_pkg::KCR_A_FWD_INTV: begin
					next_r.fwd = 1'b1;
					next_r.resp = kcr_pkg::KCR_R_DONE_INTV;
					next_r.data = 1'b1;
					next_r.data_only = 1'b1;
				end
				kcr_pkg::KCR_A_FWD_DATA: begin
					next_r.fwd = 1'b1;
					next_r.resp = kcr_pkg::KCR_R_DONE;
					next_r.data = 1'b1;
				end
				kcr_pkg::KCR_A_CANCEL_FWD: begin
					next_r.cancel = 1'b1;
					next_r.fwd = 1'b1;
					next_r.resp = kcr_pkg::KCR_R_DONE;
				end
				kcr_pkg::KCR_A_FWD_BCAST: begin
					next_r.fwd = 1'b1;
					next_r.bcast = 1'b1;
				end
				default: next_r.normal = 1'b1;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			r <= '0;
			r.ready <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	assign inc_ready_o = r.ready;
	assign res_valid_o = r.res_valid;
	assign res_resp_o = r.resp;
	assign res_data_o = r.data;
	assign res_data_only_o = r.data_only;
	assign res_fwd_o = r.fwd;
	assign res_cancel_o = r.cancel;
	assign res_bcast_o = r.bcast;
	assign res_normal_o = r.normal;
	assign res_src_o = r.src;
	assign res_type_o = r.rtype;
	assign own_live_o = r.own_live;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	logic live_now;
	assign live_now = hit && r.own_live && !fin;

	a_dkh_home_err: assert property (
		acc && live_now && r.own_kind == kcr_pkg::KCR_OWN_DKH && inc_type_i inside {kcr_pkg::KCR_RD_HOME,
		kcr_pkg::KCR_IRD_HOME, kcr_pkg::KCR_RTO_HOME, kcr_pkg::KCR_DKILL_HOME, kcr_pkg::KCR_IKILL_HOME,
		kcr_pkg::KCR_FLUSH, kcr_pkg::KCR_IORD_HOME}
		|=> res_valid_o && res_resp_o == kcr_pkg::KCR_R_ERROR && !res_fwd_o)
		else $error("home request against data kill not refused");

	a_dks_home_retry: assert property (
		acc && live_now && r.own_kind == kcr_pkg::KCR_OWN_DKS && inc_type_i inside {kcr_pkg::KCR_RD_HOME,
		kcr_pkg::KCR_IRD_HOME, kcr_pkg::KCR_RTO_HOME, kcr_pkg::KCR_DKILL_HOME, kcr_pkg::KCR_FLUSH}
		|=> res_valid_o && res_resp_o == kcr_pkg::KCR_R_RETRY)
		else $error("home request against sharer kill not retried");

	a_shr_owner_err: assert property (
		acc && live_now && r.own_kind inside {kcr_pkg::KCR_OWN_DKS, kcr_pkg::KCR_OWN_IKS}
		&& inc_type_i inside {kcr_pkg::KCR_RD_OWNER, kcr_pkg::KCR_RTO_OWNER, kcr_pkg::KCR_DKILL_SHR,
		kcr_pkg::KCR_IKILL_SHR, kcr_pkg::KCR_IORD_OWNER}
		|=> res_valid_o && res_resp_o == kcr_pkg::KCR_R_ERROR)
		else $error("owner request against sharer kill not refused");

	a_castout_err: assert property (
		acc && live_now && r.own_kind inside {kcr_pkg::KCR_OWN_DKH, kcr_pkg::KCR_OWN_DKS}
		&& inc_type_i == kcr_pkg::KCR_CASTOUT |=> res_resp_o == kcr_pkg::KCR_R_ERROR)
		else $error("castout paradox not refused");

	a_ikh_normal: assert property (
		acc && live_now && r.own_kind == kcr_pkg::KCR_OWN_IKH && inc_type_i inside {kcr_pkg::KCR_RD_OWNER,
		kcr_pkg::KCR_RTO_OWNER, kcr_pkg::KCR_DKILL_SHR, kcr_pkg::KCR_CASTOUT, kcr_pkg::KCR_IORD_OWNER}
		|=> res_valid_o && res_normal_o && res_resp_o == kcr_pkg::KCR_R_NONE)
		else $error("request against home instruction kill not passed on");

	a_tlb_fwd: assert property (
		acc && hit && inc_type_i inside {kcr_pkg::KCR_TLB_INV, kcr_pkg::KCR_TLB_SYNC}
		|=> res_fwd_o && res_resp_o == kcr_pkg::KCR_R_DONE && $past(inc_src_i) == res_src_o)
		else $error("tlb request not forwarded with done");

	a_miss_bypass: assert property (
		acc && !hit |=> res_valid_o && res_normal_o && inc_ready_o)
		else $error("other granule request did not bypass");

	a_hold_quiet: assert property (
		r.st == kcr_pkg::KCR_ST_HOLD && !fin |=> !res_valid_o && !inc_ready_o)
		else $error("resolution left hold before final response");

	a_intv_done: assert property (
		r.st == kcr_pkg::KCR_ST_HOLD && fin && own_rsp_done_i && r.own_kind == kcr_pkg::KCR_OWN_DKH
		&& r.held inside {kcr_pkg::KCR_RD_OWNER, kcr_pkg::KCR_RTO_OWNER}
		|=> res_valid_o && res_fwd_o && res_data_o && res_data_only_o && inc_ready_o
		&& res_resp_o == kcr_pkg::KCR_R_DONE_INTV)
		else $error("owner read after final done not intervened");

	a_cancel_fwd: assert property (
		r.st == kcr_pkg::KCR_ST_HOLD && fin && !own_rsp_done_i && r.held == kcr_pkg::KCR_DKILL_SHR
		|=> res_cancel_o && res_fwd_o && res_resp_o == kcr_pkg::KCR_R_DONE)
		else $error("sharer kill after retry not cancelled and forwarded");

	a_iord_home_retry: assert property (
		acc && live_now && inc_home_i && inc_type_i == kcr_pkg::KCR_IORD_HOME
		&& r.own_kind inside {kcr_pkg::KCR_OWN_DKS, kcr_pkg::KCR_OWN_IKS}
		|=> res_resp_o == kcr_pkg::KCR_R_RETRY)
		else $error("io read at home not retried");

	c_hold_entered: cover property (acc && act == kcr_pkg::KCR_A_WAIT ##[1:20] res_valid_o);
	c_bcast: cover property (res_valid_o && res_bcast_o);
	c_fin_same_cycle: cover property (acc && fin && hit);
	c_back_to_back: cover property (res_valid_o ##1 res_valid_o);
endmodule : kcr_resolver

// file: kcr_table.sv
// resolution table: outstanding kill kind and incoming request to an action
`timescale 1ns/1ns
module kcr_table (
	input wire kcr_pkg::kcr_own_e own_kind_i,
	input wire kcr_pkg::kcr_req_e req_i,
	input wire logic home_i,
	input wire kcr_pkg::kcr_cond_e cond_i,
	output kcr_pkg::kcr_act_e act_o
);
	logic home_set;
	logic owner_set;
	always_comb begin
		home_set = req_i inside {kcr_pkg::KCR_RD_HOME, kcr_pkg::KCR_IRD_HOME, kcr_pkg::KCR_RTO_HOME,
			kcr_pkg::KCR_DKILL_HOME, kcr_pkg::KCR_IKILL_HOME, kcr_pkg::KCR_FLUSH, kcr_pkg::KCR_IORD_HOME};
		owner_set = req_i inside {kcr_pkg::KCR_RD_OWNER, kcr_pkg::KCR_RTO_OWNER, kcr_pkg::KCR_DKILL_SHR,
			kcr_pkg::KCR_IKILL_SHR, kcr_pkg::KCR_IORD_OWNER};
		act_o = kcr_pkg::KCR_A_NORMAL;
		if (req_i inside {kcr_pkg::KCR_TLB_INV, kcr_pkg::KCR_TLB_SYNC}) begin
			act_o = kcr_pkg::KCR_A_FWD_DONE;
		end else begin
			case (own_kind_i)
				kcr_pkg::KCR_OWN_DKH: begin
					if (req_i == kcr_pkg::KCR_IKILL_SHR) begin
						act_o = kcr_pkg::KCR_A_FWD_DONE;
					end else if (req_i inside {kcr_pkg::KCR_RD_OWNER, kcr_pkg::KCR_RTO_OWNER}) begin
						case (cond_i)
							kcr_pkg::KCR_C_LIVE: act_o = kcr_pkg::KCR_A_WAIT;
							kcr_pkg::KCR_C_FDONE: act_o = kcr_pkg::KCR_A_FWD_INTV;
							default: act_o = kcr_pkg::KCR_A_ERROR;
						endcase
					end else if (req_i == kcr_pkg::KCR_IORD_OWNER) begin
						case (cond_i)
							kcr_pkg::KCR_C_LIVE: act_o = kcr_pkg::KCR_A_WAIT;
							kcr_pkg::KCR_C_FDONE: act_o = kcr_pkg::KCR_A_FWD_DATA;
							default: act_o = kcr_pkg::KCR_A_ERROR;
						endcase
					end else if (req_i == kcr_pkg::KCR_DKILL_SHR) begin
						case (cond_i)
							kcr_pkg::KCR_C_LIVE: act_o = kcr_pkg::KCR_A_WAIT;
							kcr_pkg::KCR_C_FDONE: act_o = kcr_pkg::KCR_A_ERROR;
							default: act_o = kcr_pkg::KCR_A_CANCEL_FWD;
						endcase
					end else if (cond_i == kcr_pkg::KCR_C_LIVE && (home_set || req_i == kcr_pkg::KCR_CASTOUT)) begin
						act_o = kcr_pkg::KCR_A_ERROR;
					end
				end
				kcr_pkg::KCR_OWN_IKH: begin
					if (req_i == kcr_pkg::KCR_IKILL_SHR) begin
						act_o = kcr_pkg::KCR_A_FWD_DONE;
					end else if (cond_i == kcr_pkg::KCR_C_LIVE && home_set) begin
						act_o = kcr_pkg::KCR_A_ERROR;
					end else begin
						act_o = kcr_pkg::KCR_A_NORMAL;
					end
				end
				default: begin
					// both sharer kinds share the io read path
					if (req_i == kcr_pkg::KCR_IORD_HOME) begin
						if (home_i && cond_i == kcr_pkg::KCR_C_LIVE) begin
							act_o = kcr_pkg::KCR_A_RETRY;
						end else if (!home_i) begin
							case (cond_i)
								kcr_pkg::KCR_C_LIVE: act_o = kcr_pkg::KCR_A_WAIT;
								kcr_pkg::KCR_C_FDONE: act_o = kcr_pkg::KCR_A_FWD_DATA;
								default: act_o = kcr_pkg::KCR_A_ERROR;
							endcase
						end
					end else if (req_i == kcr_pkg::KCR_IKILL_HOME) begin
						act_o = kcr_pkg::KCR_A_FWD_BCAST;
					end else if (cond_i != kcr_pkg::KCR_C_LIVE) begin
						act_o = kcr_pkg::KCR_A_NORMAL;
					end else if (owner_set) begin
						act_o = kcr_pkg::KCR_A_ERROR;
					end else if (own_kind_i == kcr_pkg::KCR_OWN_DKS) begin
						if (req_i == kcr_pkg::KCR_CASTOUT) begin
							act_o = kcr_pkg::KCR_A_ERROR;
						end else begin
							act_o = kcr_pkg::KCR_A_RETRY;
						end
					end else begin
						act_o = kcr_pkg::KCR_A_NORMAL;
					end
				end
			endcase
		end
	end
endmodule : kcr_table

// file: tb_kill_collision_resolver.sv
// testbench: colliding requests against each kind of own kill request
`timescale 1ns/1ns
module tb_kill_collision_resolver;
	localparam logic [31:0] BASE = 32'h0000_1000;
	// result vector: resp, data, data only, forward, cancel, broadcast, normal
	localparam logic [8:0] E_ERR = {kcr_pkg::KCR_R_ERROR, 6'h00};
	localparam logic [8:0] E_RTY = {kcr_pkg::KCR_R_RETRY, 6'h00};
	localparam logic [8:0] E_FWD = {kcr_pkg::KCR_R_DONE, 6'h08};
	localparam logic [8:0] E_DDAT = {kcr_pkg::KCR_R_DONE, 6'h28};
	localparam logic [8:0] E_CAN = {kcr_pkg::KCR_R_DONE, 6'h0C};
	localparam logic [8:0] E_INTV = {kcr_pkg::KCR_R_DONE_INTV, 6'h38};
	localparam logic [8:0] E_BC = {kcr_pkg::KCR_R_NONE, 6'h0A};
	localparam logic [8:0] E_NRM = 9'h001;
	logic clk_i = 1'h0, rst_b_i = 1'h0, own_issue_i = 1'h0, own_retire_i = 1'h0, inc_valid_i = 1'h0;
	logic inc_home_i = 1'h0, ask = 1'h0, ok = 1'h0, rv, rd, rf;
	kcr_pkg::kcr_own_e own_kind_i = kcr_pkg::KCR_OWN_DKH;
	kcr_pkg::kcr_req_e inc_type_i = kcr_pkg::KCR_RD_HOME;
	kcr_pkg::kcr_req_e res_type_o;
	kcr_pkg::kcr_resp_e res_resp_o;
	logic [31:0] own_addr_i = 32'h0000_0000, inc_addr_i = 32'h0000_0000;
	logic [7:0] inc_src_i = 8'h00, res_src_o;
	logic [3:0] lat = 4'h1;
	logic inc_ready_o, res_valid_o, res_data_o, res_data_only_o, res_fwd_o, res_cancel_o, res_bcast_o;
	logic res_normal_o, own_live_o;
	int fails = 0, n_tests = 0;
	// request codes: home-side, home-side without instruction kill and io read, owner-side, and the bypass sets
	logic [3:0] hs7[7] = '{4'h0, 4'h1, 4'h3, 4'h5, 4'hA, 4'hC, 4'hD};
	logic [3:0] hs5[5] = '{4'h0, 4'h1, 4'h3, 4'h5, 4'hC};
	logic [3:0] os5[5] = '{4'h2, 4'h4, 4'h6, 4'hB, 4'hE};
	logic [3:0] ikn[5] = '{4'h2, 4'h4, 4'h6, 4'h7, 4'hE};
	logic [3:0] iksn[6] = '{4'h0, 4'h1, 4'h3, 4'h5, 4'h7, 4'hC};

	kcr_resolver i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .own_issue_i(own_issue_i), .own_kind_i(own_kind_i),
		.own_addr_i(own_addr_i), .own_rsp_valid_i(rv), .own_rsp_done_i(rd), .own_rsp_final_i(rf),
		.own_retire_i(own_retire_i), .inc_valid_i(inc_valid_i), .inc_type_i(inc_type_i),
		.inc_addr_i(inc_addr_i), .inc_src_i(inc_src_i), .inc_home_i(inc_home_i), .inc_ready_o(inc_ready_o),
		.res_valid_o(res_valid_o), .res_resp_o(res_resp_o), .res_data_o(res_data_o),
		.res_data_only_o(res_data_only_o), .res_fwd_o(res_fwd_o), .res_cancel_o(res_cancel_o),
		.res_bcast_o(res_bcast_o), .res_normal_o(res_normal_o), .res_src_o(res_src_o),
		.res_type_o(res_type_o), .own_live_o(own_live_o));
	kcr_fabric_model i_fab (.clk_i(clk_i), .rst_b_i(rst_b_i), .ask_i(ask), .lat_i(lat), .ok_i(ok),
		.rsp_valid_o(rv), .rsp_done_o(rd), .rsp_final_o(rf));

	initial begin
		forever #5 clk_i = ~clk_i;
	end

	task automatic summarize;
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : summarize

	task automatic chk_flag(input logic [2:0] g, input logic [2:0] e);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("Error %0t: live/ready/valid got %b want %b", $time, g, e);
		end
	endtask : chk_flag

	task automatic chk_res(input logic [8:0] e);
		logic [8:0] g;
		g = {res_resp_o, res_data_o, res_data_only_o, res_fwd_o, res_cancel_o, res_bcast_o, res_normal_o};
		n_tests++;
		if (res_valid_o !== 1'h1 || inc_ready_o !== 1'h1 || g !== e || res_type_o !== inc_type_i
				|| res_src_o !== inc_src_i) begin
			fails++;
			$display("Error %0t: type %0h result %h want %h", $time, inc_type_i, g, e);
		end
	endtask : chk_res

	// all drivers enter at a falling edge
	task automatic send(input logic [3:0] t, input logic [31:0] a, input logic h);
		for (int i = 0; i < 50 && inc_ready_o !== 1'h1; i++) @(negedge clk_i);
		inc_valid_i <= 1'h1;
		inc_type_i <= kcr_pkg::kcr_req_e'(t);
		inc_addr_i <= a;
		inc_home_i <= h;
		inc_src_i <= inc_src_i + 8'h01;
		@(negedge clk_i);
		inc_valid_i <= 1'h0;
	endtask : send

	task automatic res(input logic [8:0] e);
		for (int i = 0; i < 50 && res_valid_o !== 1'h1; i++) @(negedge clk_i);
		chk_res(e);
	endtask : res

	task automatic req(input logic [3:0] t, input logic [31:0] a, input logic h, input logic [8:0] e);
		send(t, a, h);
		res(e);
		// one idle edge so the next request never re-drives the strobe in this time step
		@(negedge clk_i);
	endtask : req

	task automatic issue(input logic [1:0] k, input logic [31:0] a);
		own_issue_i <= 1'h1;
		own_kind_i <= kcr_pkg::kcr_own_e'(k);
		own_addr_i <= a;
		@(negedge clk_i);
		own_issue_i <= 1'h0;
		@(negedge clk_i);
	endtask : issue

	task automatic fin(input logic o, input logic [3:0] l);
		ask <= 1'h1;
		ok <= o;
		lat <= l;
		@(negedge clk_i);
		ask <= 1'h0;
	endtask : fin

	// dependent row: final done (slow train), final retry (prompt), then nothing outstanding
	task automatic t_wait(input logic [1:0] k, input logic [3:0] t, input logic h, input logic [8:0] e_done,
			input logic [8:0] e_rty, input logic [8:0] e_none);
		for (int j = 0; j < 2; j++) begin
			issue(k, BASE);
			send(t, BASE, h);
			repeat (3) begin
				@(negedge clk_i);
				chk_flag({own_live_o, inc_ready_o, res_valid_o}, 3'h4);
			end
			fin(j == 0, (j == 0) ? 4'h6 : 4'h1);
			res((j == 0) ? e_done : e_rty);
		end
		issue(k, BASE);
		fin(1'h1, 4'h2);
		for (int i = 0; i < 50 && own_live_o !== 1'h0; i++) @(negedge clk_i);
		req(t, BASE, h, e_none);
		$display("wait test kind %0d type %0h done", k, t);
	endtask : t_wait

	task automatic t_dkh;
		issue(2'h0, BASE);
		chk_flag({own_live_o, inc_ready_o, res_valid_o}, 3'h6);
		foreach (hs7[i]) req(hs7[i], BASE + 32'h0000_001F, 1'h1, E_ERR);
		req(4'h7, BASE, 1'h0, E_ERR);
		req(4'h8, BASE, 1'h0, E_FWD);
		req(4'h9, BASE, 1'h0, E_FWD);
		req(4'hB, BASE, 1'h0, E_FWD);
		req(4'h0, BASE + 32'h0000_0020, 1'h1, E_NRM);
		$display("data kill home test done");
	endtask : t_dkh

	task automatic t_dks;
		issue(2'h1, BASE);
		foreach (hs5[i]) req(hs5[i], BASE, 1'h1, E_RTY);
		foreach (os5[i]) req(os5[i], BASE, 1'h0, E_ERR);
		req(4'h7, BASE, 1'h0, E_ERR);
		req(4'hA, BASE, 1'h0, E_BC);
		req(4'hD, BASE, 1'h1, E_RTY);
		$display("data kill sharer test done");
	endtask : t_dks

	task automatic t_ikh;
		issue(2'h2, BASE);
		foreach (hs7[i]) req(hs7[i], BASE, 1'h1, E_ERR);
		foreach (ikn[i]) req(ikn[i], BASE, 1'h0, E_NRM);
		req(4'hB, BASE, 1'h0, E_FWD);
		$display("instr kill home test done");
	endtask : t_ikh

	task automatic t_iks;
		issue(2'h3, BASE);
		foreach (iksn[i]) req(iksn[i], BASE, 1'h1, E_NRM);
		foreach (os5[i]) req(os5[i], BASE, 1'h0, E_ERR);
		req(4'hA, BASE, 1'h0, E_BC);
		req(4'hD, BASE, 1'h1, E_RTY);
		own_retire_i <= 1'h1;
		@(negedge clk_i);
		own_retire_i <= 1'h0;
		@(negedge clk_i);
		req(4'h2, BASE, 1'h0, E_NRM);
		$display("instr kill sharer test done");
	endtask : t_iks

	initial begin
		repeat (12) @(negedge clk_i);
		rst_b_i <= 1'h1;
		@(negedge clk_i);
		chk_flag({own_live_o, inc_ready_o, res_valid_o}, 3'h2);
		t_dkh;
		t_wait(2'h0, 4'h2, 1'h0, E_INTV, E_ERR, E_ERR);
		t_wait(2'h0, 4'h4, 1'h0, E_INTV, E_ERR, E_ERR);
		t_wait(2'h0, 4'hE, 1'h0, E_DDAT, E_ERR, E_ERR);
		t_wait(2'h0, 4'h6, 1'h0, E_ERR, E_CAN, E_CAN);
		t_wait(2'h1, 4'hD, 1'h0, E_DDAT, E_ERR, E_ERR);
		t_wait(2'h3, 4'hD, 1'h0, E_DDAT, E_ERR, E_ERR);
		t_dks;
		t_ikh;
		t_iks;
		summarize;
	end

	// the scenarios need a few hundred cycles; this leaves wide margin
	initial begin
		repeat (20000) @(posedge clk_i);
		fails++;
		summarize;
	end
endmodule : tb_kill_collision_resolver
